// *** hdl/pdc_pkg.sv ***
// Register map, field layout and reset values of the PLL divider configuration block.
package pdc_pkg;
  localparam logic [7:0] PDC_ADDR_BANK1 = 8'h0C;
  localparam logic [7:0] PDC_ADDR_LOADCAP = 8'h13;
  localparam logic [7:0] PDC_ADDR_PUMPFB = 8'h40;
  localparam logic [7:0] PDC_ADDR_FBLOW = 8'h41;
  localparam logic [7:0] PDC_ADDR_FBODDQ = 8'h42;
  localparam logic [7:0] PDC_ADDR_BANK2 = 8'h47;

  localparam logic [7:0] PDC_RST_BANK1 = 8'h08;
  localparam logic [7:0] PDC_RST_LOADCAP = 8'h00;
  localparam logic [7:0] PDC_RST_PUMPFB = 8'hC0;
  localparam logic [7:0] PDC_RST_FBLOW = 8'h00;
  localparam logic [7:0] PDC_RST_FBODDQ = 8'h00;
  localparam logic [7:0] PDC_RST_BANK2 = 8'h08;

  localparam logic [2:0] PDC_PRESET_BITS = 3'h6;
  localparam int PDC_PRESET_POS = 5;
  localparam int PDC_PUMP_POS = 2;
  localparam int PDC_FBHIGH_POS = 0;
  localparam int PDC_ODD_POS = 7;
  localparam int PDC_SRC_POS = 7;
  localparam logic [7:0] PDC_INDIV_OFFSET = 8'h02;
  localparam logic [11:0] PDC_FB_BASE_OFFSET = 12'h004;
  localparam logic [11:0] PDC_FB_MIN = 12'h008;
  localparam logic [11:0] PDC_FB_MAX = 12'h807;

  function automatic logic [11:0] pdc_fb_total(input logic [9:0] base, input logic odd);
    pdc_fb_total = (({2'h0, base} + PDC_FB_BASE_OFFSET) << 1) + {11'h000, odd};
  endfunction

  function automatic logic pdc_bank_src(input logic [7:0] r);
    pdc_bank_src = r[PDC_SRC_POS];
  endfunction

  function automatic logic [6:0] pdc_bank_ratio(input logic [7:0] r);
    pdc_bank_ratio = r[6:0];
  endfunction
endpackage

// *** hdl/pdc_bank_divider.sv ***
// One post-divider bank: fixed divide by 2, 3 and 4 plus a programmable ratio.
`timescale 1ns/1ns
module pdc_bank_divider
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic inTick,
  input wire logic [6:0] ratio,
  output logic div2Tick,
  output logic div3Tick,
  output logic div4Tick,
  output logic divNTick
);
  typedef struct packed {
    logic cnt2;
    logic [1:0] cnt3;
    logic [1:0] cnt4;
    logic [6:0] cntN;
    logic t2;
    logic t3;
    logic t4;
    logic tN;
  } pdc_bank_state_t;

  pdc_bank_state_t st;
  pdc_bank_state_t next_st;

  // Ratios below two collapse to pass-through; the host is expected to keep 4..127.
  always_comb begin
    next_st = st;
    next_st.t2 = 1'b0;
    next_st.t3 = 1'b0;
    next_st.t4 = 1'b0;
    next_st.tN = 1'b0;
    if (inTick) begin // [R10]
      next_st.cnt2 = ~st.cnt2;
      next_st.t2 = st.cnt2;
      next_st.cnt3 = (st.cnt3 == 2'h2) ? 2'h0 : st.cnt3 + 2'h1;
      next_st.t3 = (st.cnt3 == 2'h2);
      next_st.cnt4 = st.cnt4 + 2'h1;
      next_st.t4 = (st.cnt4 == 2'h3);
      if (ratio < 7'h02 || st.cntN >= ratio - 7'h01) begin
        next_st.cntN = 7'h00;
        next_st.tN = 1'b1;
      end else begin
        next_st.cntN = st.cntN + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign div2Tick = st.t2;
  assign div3Tick = st.t3;
  assign div4Tick = st.t4;
  assign divNTick = st.tN;

  property p_tickOnInput;
    @(posedge ref_clk) disable iff (!nrst)
      (div2Tick || div3Tick || div4Tick || divNTick) |-> $past(inTick);
  endproperty
  a_tickOnInput: assert property (p_tickOnInput) else $error("Bank tick without input tick."); // [R10]

  property p_div2Spacing;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(st.cnt2) |-> !div2Tick;
  endproperty
  a_div2Spacing: assert property (p_div2Spacing) else $error("Divide by two fired early."); // [R10]
endmodule // pdc_bank_divider

// *** hdl/pdc_config.sv ***
// PLL divider configuration: register file, decoded totals, predivider and two bank dividers.
// Overview of operation
// R1: Predivide code: feedback_odd_input_divide bits 6:0, plus two.
// R2: Reference divided by total ratio, 2 to 129.
// R3: Host keeps predivided reference at least 250 kHz.
// R4: Multiplier is twice base plus four, plus odd.
// R5: Base: pump_and_feedback_high[1:0], feedback_base_low; odd: feedback_odd_input_divide[7].
// R6: pump_and_feedback_high upper bits read 110, never written.
// R7: Multiplier spans 8 up to 2055.
// R8: Host keeps oscillator between 100 and 400 MHz.
// R9: Each bank muxes oscillator or reference independently.
// R10: Banks divide by 2, 3, 4 or ratio.
// R11: Host keeps bank ratios between 4 and 127.
// R12: bank1_source_ratio holds bank 1 select and ratio.
// R13: bank2_source_ratio holds bank 2 select and ratio.
// R14: Pump code in pump_and_feedback_high bits 4:2, applied.
// R15: Host picks pump code from multiplier table.
// R16: Host never writes pump codes 101 to 111.
// R17: Host keeps multiplier within 16 to 1023.
// R18: load_capacitor_setting holds eight-bit load capacitance code.
// R19: Bank 1 divide by two needs ratio multiple-of-four.
// R20: Unused bank ratio should be eight.
// R21: Decoded fields are combinational from registers.
`timescale 1ns/1ns
module pdc_config
  import pdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic refTick,
  input wire logic oscTick,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic [7:0] inputDivideTotal,
  output logic refDivTick,
  output logic [9:0] feedbackBaseCode,
  output logic feedbackOddBit,
  output logic [11:0] feedbackMultiplier,
  output logic [2:0] pumpCode,
  output logic [7:0] loadCapacitanceCode,
  output logic bank1SourceSelect,
  output logic bank2SourceSelect,
  output logic [6:0] bank1Ratio,
  output logic [6:0] bank2Ratio,
  output logic bank1InputClock,
  output logic bank2InputClock,
  output logic bank1Div2Tick,
  output logic bank1Div3Tick,
  output logic bank1Div4Tick,
  output logic bank1DivNTick,
  output logic bank2Div2Tick,
  output logic bank2Div3Tick,
  output logic bank2Div4Tick,
  output logic bank2DivNTick
);
  typedef struct packed {
    logic [7:0] bank1;
    logic [7:0] loadCap;
    logic [7:0] pumpFb;
    logic [7:0] fbLow;
    logic [7:0] fbOddQ;
    logic [7:0] bank2;
    logic [7:0] rdata;
    logic [7:0] preCnt;
    logic preTick;
  } pdc_cfg_state_t;

  pdc_cfg_state_t st;
  pdc_cfg_state_t next_st;
  logic [7:0] readMux;

  // Unmapped and reserved addresses read as zero; writes to them are dropped.
  always_comb begin
    unique case (regAddr)
      PDC_ADDR_BANK1: readMux = st.bank1; // [R12]
      PDC_ADDR_LOADCAP: readMux = st.loadCap; // [R18]
      PDC_ADDR_PUMPFB: readMux = st.pumpFb; // [R6]
      PDC_ADDR_FBLOW: readMux = st.fbLow; // [R5]
      PDC_ADDR_FBODDQ: readMux = st.fbOddQ; // [R1]
      PDC_ADDR_BANK2: readMux = st.bank2; // [R13]
      default: readMux = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.preTick = 1'b0;
    if (regRead) begin
      next_st.rdata = readMux;
    end
    if (regWrite) begin
      unique case (regAddr)
        PDC_ADDR_BANK1: next_st.bank1 = regWdata; // [R12]
        PDC_ADDR_LOADCAP: next_st.loadCap = regWdata; // [R18]
        PDC_ADDR_PUMPFB: next_st.pumpFb = {PDC_PRESET_BITS, regWdata[4:0]}; // [R6] [R14]
        PDC_ADDR_FBLOW: next_st.fbLow = regWdata; // [R5]
        PDC_ADDR_FBODDQ: next_st.fbOddQ = regWdata; // [R1] [R5]
        PDC_ADDR_BANK2: next_st.bank2 = regWdata; // [R13]
        default: next_st.bank1 = st.bank1;
      endcase
    end
    // The count restarts on wrap only, so a new ratio takes hold within one period.
    if (refTick) begin // [R2]
      if (st.preCnt >= inputDivideTotal - 8'h01) begin
        next_st.preCnt = 8'h00;
        next_st.preTick = 1'b1;
      end else begin
        next_st.preCnt = st.preCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st.bank1 <= PDC_RST_BANK1;
      st.loadCap <= PDC_RST_LOADCAP;
      st.pumpFb <= PDC_RST_PUMPFB;
      st.fbLow <= PDC_RST_FBLOW;
      st.fbOddQ <= PDC_RST_FBODDQ;
      st.bank2 <= PDC_RST_BANK2;
      st.rdata <= 8'h00;
      st.preCnt <= 8'h00;
      st.preTick <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata = st.rdata;
  assign refDivTick = st.preTick;
  assign inputDivideTotal = {1'b0, st.fbOddQ[6:0]} + PDC_INDIV_OFFSET; // [R1] [R21]
  assign feedbackBaseCode = {st.pumpFb[PDC_FBHIGH_POS+1:PDC_FBHIGH_POS], st.fbLow}; // [R5]
  assign feedbackOddBit = st.fbOddQ[PDC_ODD_POS]; // [R5]
  assign feedbackMultiplier = pdc_fb_total(feedbackBaseCode, feedbackOddBit); // [R4] [R21]
  assign pumpCode = st.pumpFb[PDC_PUMP_POS+2:PDC_PUMP_POS]; // [R14] [R21]
  assign loadCapacitanceCode = st.loadCap; // [R18]
  assign bank1SourceSelect = pdc_bank_src(st.bank1); // [R12] [R21]
  assign bank2SourceSelect = pdc_bank_src(st.bank2); // [R13] [R21]
  assign bank1Ratio = pdc_bank_ratio(st.bank1); // [R12] [R21]
  assign bank2Ratio = pdc_bank_ratio(st.bank2); // [R13] [R21]
  // Select high feeds the oscillator, low feeds the reference.
  assign bank1InputClock = bank1SourceSelect ? oscTick : refTick; // [R9]
  assign bank2InputClock = bank2SourceSelect ? oscTick : refTick; // [R9]

  pdc_bank_divider uBank1 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inTick(bank1InputClock),
    .ratio(bank1Ratio),
    .div2Tick(bank1Div2Tick),
    .div3Tick(bank1Div3Tick),
    .div4Tick(bank1Div4Tick),
    .divNTick(bank1DivNTick)
  );

  pdc_bank_divider uBank2 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inTick(bank2InputClock),
    .ratio(bank2Ratio),
    .div2Tick(bank2Div2Tick),
    .div3Tick(bank2Div3Tick),
    .div4Tick(bank2Div4Tick),
    .divNTick(bank2DivNTick)
  );

  property p_qTotalWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_FBODDQ)
        |=> inputDivideTotal == {1'b0, $past(regWdata[6:0])} + 8'h02;
  endproperty
  a_qTotalWrite: assert property (p_qTotalWrite) else $error("Predivide total wrong."); // [R1]

  property p_qTotalRange;
    @(posedge ref_clk) disable iff (!nrst)
      inputDivideTotal >= 8'h02 && inputDivideTotal <= 8'h81;
  endproperty
  a_qTotalRange: assert property (p_qTotalRange) else $error("Predivide total out of span."); // [R2]

  property p_preTickCause;
    @(posedge ref_clk) disable iff (!nrst)
      refDivTick |-> $past(refTick) && st.preCnt == 8'h00;
  endproperty
  a_preTickCause: assert property (p_preTickCause) else $error("Predivider tick unexpected."); // [R2]

  property p_preDivTwo;
    @(posedge ref_clk) disable iff (!nrst)
      (inputDivideTotal == 8'h02 && refTick && st.preCnt == 8'h00 && !regWrite)
        ##1 (refTick && !regWrite) |=> refDivTick;
  endproperty
  a_preDivTwo: assert property (p_preDivTwo) else $error("Divide by two tick missing."); // [R2]

  property p_fbWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_FBLOW)
        |=> feedbackMultiplier == 12'(({4'h0, $past(regWdata)}
          + {2'h0, st.pumpFb[1:0], 8'h00} + 12'h004) * 2) + {11'h000, feedbackOddBit};
  endproperty
  a_fbWrite: assert property (p_fbWrite) else $error("Feedback multiplier wrong."); // [R4] [R5]

  property p_fbRange;
    @(posedge ref_clk) disable iff (!nrst)
      feedbackMultiplier >= PDC_FB_MIN && feedbackMultiplier <= PDC_FB_MAX;
  endproperty
  a_fbRange: assert property (p_fbRange) else $error("Feedback multiplier out of span."); // [R7]

  property p_presetRead;
    @(posedge ref_clk) disable iff (!nrst)
      (regRead && regAddr == PDC_ADDR_PUMPFB) |=> regRdata[7:5] == 3'h6;
  endproperty
  a_presetRead: assert property (p_presetRead) else $error("Preset bits changed."); // [R6]

  property p_srcMux;
    @(posedge ref_clk) disable iff (!nrst)
      bank1InputClock == (bank1SourceSelect ? oscTick : refTick)
        && bank2InputClock == (bank2SourceSelect ? oscTick : refTick);
  endproperty
  a_srcMux: assert property (p_srcMux) else $error("Bank source mux wrong."); // [R9]

  property p_bank1Write;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_BANK1)
        |=> bank1Ratio == $past(regWdata[6:0]) && bank1SourceSelect == $past(regWdata[7]);
  endproperty
  a_bank1Write: assert property (p_bank1Write) else $error("Bank 1 fields wrong."); // [R12]

  property p_bank2Write;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_BANK2)
        |=> bank2Ratio == $past(regWdata[6:0]) && bank2SourceSelect == $past(regWdata[7]);
  endproperty
  a_bank2Write: assert property (p_bank2Write) else $error("Bank 2 fields wrong."); // [R13]

  property p_pumpWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_PUMPFB) |=> pumpCode == $past(regWdata[4:2]);
  endproperty
  a_pumpWrite: assert property (p_pumpWrite) else $error("Pump code wrong."); // [R14]

  property p_capWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_LOADCAP) |=> loadCapacitanceCode == $past(regWdata);
  endproperty
  a_capWrite: assert property (p_capWrite) else $error("Load capacitance code wrong."); // [R18]

  property p_unmappedRead;
    @(posedge ref_clk) disable iff (!nrst)
      (regRead && regAddr == 8'h43) |=> regRdata == 8'h00;
  endproperty
  a_unmappedRead: assert property (p_unmappedRead) else $error("Unmapped read not zero.");

  // Read data stands between reads, so a slow host may still fetch it.
  property p_rdataHold;
    @(posedge ref_clk) disable iff (!nrst)
      !regRead |=> $stable(regRdata);
  endproperty
  a_rdataHold: assert property (p_rdataHold) else $error("Read data changed without read.");

  property p_unmappedWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == 8'h43)
        |=> $stable({st.bank1, st.loadCap, st.pumpFb, st.fbLow, st.fbOddQ, st.bank2});
  endproperty
  a_unmappedWrite: assert property (p_unmappedWrite) else $error("Unmapped write landed.");

  property p_oddWrite;
    @(posedge ref_clk) disable iff (!nrst)
      (regWrite && regAddr == PDC_ADDR_FBODDQ)
        |=> feedbackOddBit == $past(regWdata[7]);
  endproperty
  a_oddWrite: assert property (p_oddWrite) else $error("Odd bit wrong."); // [R5]

  property p_preTickGap;
    @(posedge ref_clk) disable iff (!nrst)
      refDivTick |=> !refDivTick;
  endproperty
  a_preTickGap: assert property (p_preTickGap) else $error("Predivider ticks back to back."); // [R2]

  property p_covPredivTick;
    @(posedge ref_clk) disable iff (!nrst)
      refDivTick ##[1:200] refDivTick;
  endproperty
  c_covPredivTick: cover property (p_covPredivTick);

  property p_covOscBank;
    @(posedge ref_clk) disable iff (!nrst)
      bank1SourceSelect && bank1DivNTick;
  endproperty
  c_covOscBank: cover property (p_covOscBank);

  property p_covFbMax;
    @(posedge ref_clk) disable iff (!nrst)
      feedbackMultiplier == PDC_FB_MAX;
  endproperty
  c_covFbMax: cover property (p_covFbMax);

  property p_covBank2Div3;
    @(posedge ref_clk) disable iff (!nrst)
      bank2Div3Tick;
  endproperty
  c_covBank2Div3: cover property (p_covBank2Div3);
endmodule // pdc_config

// *** verification/pdc_config_bench.sv ***
// Self-checking testbench for the PLL divider configuration block.
`timescale 1ns/1ns
module pdc_config_bench;
  import pdc_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic refTick = 1'b0;
  logic oscTick = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] inputDivideTotal;
  logic refDivTick;
  logic [9:0] feedbackBaseCode;
  logic feedbackOddBit;
  logic [11:0] feedbackMultiplier;
  logic [2:0] pumpCode;
  logic [7:0] loadCapacitanceCode;
  logic bank1SourceSelect, bank2SourceSelect;
  logic [6:0] bank1Ratio, bank2Ratio;
  logic bank1InputClock, bank2InputClock;
  logic bank1Div2Tick, bank1Div3Tick, bank1Div4Tick, bank1DivNTick;
  logic bank2Div2Tick, bank2Div3Tick, bank2Div4Tick, bank2DivNTick;
  int n_fail = 0;
  int checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  pdc_config pdc_config_i (
    .ref_clk(ref_clk), .nrst(nrst), .refTick(refTick), .oscTick(oscTick),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .inputDivideTotal(inputDivideTotal), .refDivTick(refDivTick),
    .feedbackBaseCode(feedbackBaseCode), .feedbackOddBit(feedbackOddBit),
    .feedbackMultiplier(feedbackMultiplier), .pumpCode(pumpCode),
    .loadCapacitanceCode(loadCapacitanceCode), .bank1SourceSelect(bank1SourceSelect),
    .bank2SourceSelect(bank2SourceSelect), .bank1Ratio(bank1Ratio), .bank2Ratio(bank2Ratio),
    .bank1InputClock(bank1InputClock), .bank2InputClock(bank2InputClock),
    .bank1Div2Tick(bank1Div2Tick), .bank1Div3Tick(bank1Div3Tick),
    .bank1Div4Tick(bank1Div4Tick), .bank1DivNTick(bank1DivNTick),
    .bank2Div2Tick(bank2Div2Tick), .bank2Div3Tick(bank2Div3Tick),
    .bank2Div4Tick(bank2Div4Tick), .bank2DivNTick(bank2DivNTick)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Every drive lands the same small delay after a rising edge.
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask

  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    step();
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    step();
    regRead = 1'b1;
    regAddr = a;
    step();
    regRead = 1'b0;
    d = regRdata;
  endtask

  // The last entry is an unmapped place, which must read as zero and ignore writes.
  logic [7:0] addrs [7] = '{PDC_ADDR_BANK1, PDC_ADDR_LOADCAP, PDC_ADDR_PUMPFB,
                            PDC_ADDR_FBLOW, PDC_ADDR_FBODDQ, PDC_ADDR_BANK2, 8'h43};
  logic [7:0] rsts [7] = '{PDC_RST_BANK1, PDC_RST_LOADCAP, PDC_RST_PUMPFB,
                           PDC_RST_FBLOW, PDC_RST_FBODDQ, PDC_RST_BANK2, 8'h00};
  logic [7:0] wvals [7] = '{8'h85, 8'hA5, 8'h13, 8'hFF, 8'h81, 8'h06, 8'h5A};
  logic [7:0] rvals [7] = '{8'h85, 8'hA5, 8'hD3, 8'hFF, 8'h81, 8'h06, 8'h00};

  task automatic reset_values();
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(addrs[i], d);
      cmp($sformatf("reset %0h", addrs[i]), {4'h0, rsts[i]}, {4'h0, d});
    end
    cmp("divide total", 12'h002, {4'h0, inputDivideTotal});
    cmp("pmult", 12'h008, feedbackMultiplier);
  endtask

  task automatic map_and_decode();
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      wr(addrs[i], wvals[i]);
    end
    for (int i = 0; i < 7; i++) begin
      rd(addrs[i], d);
      cmp($sformatf("readback %0h", addrs[i]), {4'h0, rvals[i]}, {4'h0, d});
    end
    cmp("divide total", 12'h003, {4'h0, inputDivideTotal});
    cmp("base", 12'h3FF, {2'h0, feedbackBaseCode});
    cmp("odd", 12'h001, {11'h000, feedbackOddBit});
    cmp("pmult", 12'h807, feedbackMultiplier);
    cmp("pump", 12'h004, {9'h000, pumpCode});
    cmp("loadcap", 12'h0A5, {4'h0, loadCapacitanceCode});
    cmp("src1", 12'h001, {11'h000, bank1SourceSelect});
    cmp("ratio1", 12'h005, {5'h00, bank1Ratio});
    cmp("src2", 12'h000, {11'h000, bank2SourceSelect});
    cmp("ratio2", 12'h006, {5'h00, bank2Ratio});
    // Smallest multiplier and largest predivide together.
    wr(PDC_ADDR_FBLOW, 8'h00);
    wr(PDC_ADDR_FBODDQ, 8'h7F);
    for (int c = 0; c < 5; c++) begin
      wr(PDC_ADDR_PUMPFB, 8'(c << 2));
      cmp("pump", 12'(c), {9'h000, pumpCode});
      cmp("pmult", 12'h008, feedbackMultiplier);
    end
    wr(PDC_ADDR_FBLOW, 8'h2A);
    cmp("pmult", 12'((12'h02A + 12'h004) * 2), feedbackMultiplier);
    cmp("divide total", 12'h081, {4'h0, inputDivideTotal});
  endtask

  // Pulses one tick source every cycle for n cycles and counts every tick output.
  task automatic run_ticks(input logic osc, input logic rf, input int n, output int cnt [11]);
    logic [10:0] s;
    for (int j = 0; j < 11; j++) begin
      cnt[j] = 0;
    end
    for (int k = 0; k < n + 3; k++) begin
      step();
      s = {bank1InputClock, bank2InputClock, bank1Div2Tick, bank1Div3Tick, bank1Div4Tick,
           bank1DivNTick, bank2Div2Tick, bank2Div3Tick, bank2Div4Tick, bank2DivNTick,
           refDivTick};
      for (int j = 0; j < 11; j++) begin
        if (s[10 - j] === 1'b1) begin
          cnt[j]++;
        end
      end
      oscTick = (k < n) ? osc : 1'b0;
      refTick = (k < n) ? rf : 1'b0;
    end
  endtask

  task automatic dividers();
    int cnt [11];
    int expOsc [11] = '{20, 0, 10, 6, 5, 2, 0, 0, 0, 0, 0};
    int expRef [11] = '{0, 12, 0, 0, 0, 0, 6, 4, 3, 2, 4};
    int expTwo [11] = '{0, 8, 0, 0, 0, 0, 4, 2, 2, 1, 4};
    // A short reset in mid-run clears every divider count before the tick checks.
    nrst = 1'b0;
    repeat (3) step();
    nrst = 1'b1;
    cmp("pmult", 12'h008, feedbackMultiplier);
    // Bank 1 idles at ratio eight while only the reference runs.
    wr(PDC_ADDR_BANK1, 8'h88);
    wr(PDC_ADDR_BANK2, 8'h06);
    wr(PDC_ADDR_FBODDQ, 8'h01);
    wr(PDC_ADDR_FBLOW, 8'h10);
    cmp("pmult", 12'h028, feedbackMultiplier);
    run_ticks(1'b1, 1'b0, 20, cnt);
    for (int j = 0; j < 11; j++) begin
      cmp($sformatf("osc tick %0d", j), 12'(expOsc[j]), 12'(cnt[j]));
    end
    run_ticks(1'b0, 1'b1, 12, cnt);
    for (int j = 0; j < 11; j++) begin
      cmp($sformatf("ref tick %0d", j), 12'(expRef[j]), 12'(cnt[j]));
    end
    // Smallest predivide total with a reference tick on every cycle.
    wr(PDC_ADDR_FBODDQ, 8'h00);
    run_ticks(1'b0, 1'b1, 8, cnt);
    for (int j = 0; j < 11; j++) begin
      cmp($sformatf("half tick %0d", j), 12'(expTwo[j]), 12'(cnt[j]));
    end
  endtask

  // Watchdog: a hung run counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (20) step();
    nrst = 1'b1;
    reset_values();
    map_and_decode();
    dividers();
    close_out();
  end
endmodule // pdc_config_bench
